// ### verilog/input_port_defs.vh
// constants for the nine-bit input port with mismatch interrupts
`ifndef INPUT_PORT_DEFS_VH
`define INPUT_PORT_DEFS_VH

`define ADDR_W           4
`define OFF_INT_SEL0     4'h0
`define OFF_INT_SEL1     4'h1
`define OFF_CMP_POL0     4'h2
`define OFF_CMP_POL1     4'h3
`define OFF_PORT_DATA0   4'h4
`define OFF_PORT_DATA1   4'h5
`define OFF_INT_STATUS   4'h6
`define OFF_INT_ENABLE   4'h7
`define OFF_PRIORITY     4'h8
`define OFF_RESERVED1    4'h9

`define INT_SEL_RESET    9'h000
`define CMP_POL_RESET    9'h1ff
`define RSV_RESET        2'h2
`define PRIO_RESET       4'h0
`define PULLUP_DEFAULT   9'h1ff

`define GRP_LOW          0
`define GRP_HIGH         1
`define GRP_EXTRA        2

`define VEC_EXTRA        24'h00000a
`define VEC_HIGH         24'h00000c
`define VEC_LOW          24'h00000e

`endif

// ### verilog/input_port_edge_interrupt.v
// nine-bit input port with per-group mismatch interrupts
// Notes on behaviour
// - nine readable input bits, eight plus one
// - extra pin also drives timer event clock
// - port read returns live pins, no latch
// - per-bit pull-up is a static parameter
// - three groups: bits 0-3, 4-7, extra
// - met condition sets group flag and request
// - group enable masks request to CPU
// - two-bit priority for bank and extra
// - vectors 0a extra, 0c high, 0e low
// - per-bit select includes bit in detection
// - per-bit polarity picks rising or falling
// - flag sets on match to mismatch only
// - rearm only after return to match
// - deselected bits ignored in evaluation
// - select bits rw, reset to zero
// - polarity bits rw, reset to one
`timescale 1ns/1ps
`default_nettype none
`include "input_port_defs.vh"

module input_port_edge_interrupt #(
  parameter [8:0] PULLUP_FITTED = `PULLUP_DEFAULT
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // pins
  input  wire [7:0]  bank0_input_pins,
  input  wire        extra_input_pin,
  output wire [8:0]  pullup_enable,
  output wire        event_counter_clock_in,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // interrupt
  output wire        irq,
  output wire [2:0]  group_irq,
  output wire [1:0]  bank0_priority,
  output wire [1:0]  extra_priority,
  output reg  [23:0] irq_vector
);

  // register index map, one byte each:
  //   0 select bits 7..0
  //   1 select bit 8 in bit 0, spare bit in bit 1
  //   2 polarity bits 7..0
  //   3 polarity bit 8 in bit 0, spare bit in bit 1
  //   4 live pins 7..0
  //   5 live extra pin in bit 0
  //   6 group flags {extra, high, low}, write one to clear
  //   7 group enables {extra, high, low}
  //   8 priorities {extra, bank}
  //   other indexes read as zero, writes dropped

  reg  [8:0] per_bit_int_select_q;
  reg  [8:0] per_bit_compare_polarity_q;
  reg  [1:0] reserved_q;
  reg  [2:0] group_factor_flag_q;
  reg  [2:0] group_int_enable_q;
  reg  [3:0] priority_q;
  reg  [8:0] pin_meta_q;
  reg  [8:0] pin_sync_q;
  reg  [2:0] mismatch_q;
  wire [8:0] pins_live;
  wire [8:0] bit_mismatch;
  wire [2:0] mismatch_d;
  wire [2:0] set_pulse;
  wire [2:0] clr_mask;
  wire       wr_sel1;
  wire       wr_pol1;
  wire       wr_sel0;
  wire       wr_pol0;
  wire       wr_status;
  wire       wr_enable;
  wire       wr_prio;
  reg  [2:0] flag_d;
  reg  [7:0] rdata_d;
  reg  [23:0] vector_d;

  assign pins_live              = {extra_input_pin, bank0_input_pins};
  assign event_counter_clock_in = extra_input_pin;
  assign pullup_enable          = PULLUP_FITTED;

  // pins are two-flop synchronised before evaluation
  // first stage: only the second stage may read it
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta_q <= 9'h000;
    end else begin
      pin_meta_q <= pins_live;
    end
  end

  // second stage feeds the match logic
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_sync_q <= 9'h000;
    end else begin
      pin_sync_q <= pin_meta_q;
    end
  end

  // polarity 1 means falling edge: match while pin high
  genvar i;
  generate
    for (i = 0; i < 9; i = i + 1) begin : g_bit
      assign bit_mismatch[i] = per_bit_int_select_q[i] &
                               (pin_sync_q[i] != per_bit_compare_polarity_q[i]);
    end
  endgenerate

  assign mismatch_d = {bit_mismatch[8], |bit_mismatch[7:4], |bit_mismatch[3:0]};

  // only a rise of the group mismatch sets; rewriting polarity back rearms
  assign set_pulse = mismatch_d & ~mismatch_q;

  // write decode, one strobe per writable register
  assign wr_sel0   = reg_wr && (reg_addr == `OFF_INT_SEL0);
  assign wr_sel1   = reg_wr && (reg_addr == `OFF_INT_SEL1);
  assign wr_pol0   = reg_wr && (reg_addr == `OFF_CMP_POL0);
  assign wr_pol1   = reg_wr && (reg_addr == `OFF_CMP_POL1);
  assign wr_status = reg_wr && (reg_addr == `OFF_INT_STATUS);
  assign wr_enable = reg_wr && (reg_addr == `OFF_INT_ENABLE);
  assign wr_prio   = reg_wr && (reg_addr == `OFF_PRIORITY);

  assign clr_mask = wr_status ? reg_wdata[2:0] : 3'h0;

  // next flag state; a set wins over a write-one clear in the same cycle
  // so an event landing during the clear is never lost
  always @* begin
    flag_d = group_factor_flag_q;
    if (clr_mask[`GRP_LOW]) begin
      flag_d[`GRP_LOW] = 1'b0;
    end
    if (set_pulse[`GRP_LOW]) begin
      flag_d[`GRP_LOW] = 1'b1;
    end
    if (clr_mask[`GRP_HIGH]) begin
      flag_d[`GRP_HIGH] = 1'b0;
    end
    if (set_pulse[`GRP_HIGH]) begin
      flag_d[`GRP_HIGH] = 1'b1;
    end
    if (clr_mask[`GRP_EXTRA]) begin
      flag_d[`GRP_EXTRA] = 1'b0;
    end
    if (set_pulse[`GRP_EXTRA]) begin
      flag_d[`GRP_EXTRA] = 1'b1;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mismatch_q          <= 3'h0;
      group_factor_flag_q <= 3'h0;
    end else begin
      mismatch_q          <= mismatch_d;
      group_factor_flag_q <= flag_d;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      per_bit_int_select_q       <= `INT_SEL_RESET;
      per_bit_compare_polarity_q <= `CMP_POL_RESET;
      reserved_q                 <= `RSV_RESET;
      group_int_enable_q         <= 3'h0;
      priority_q                 <= `PRIO_RESET;
    end else begin
      if (wr_sel0) begin
        per_bit_int_select_q[7:0] <= reg_wdata;
      end
      if (wr_sel1) begin
        per_bit_int_select_q[8] <= reg_wdata[0];
        reserved_q[0]           <= reg_wdata[1];
      end
      if (wr_pol0) begin
        per_bit_compare_polarity_q[7:0] <= reg_wdata;
      end
      if (wr_pol1) begin
        per_bit_compare_polarity_q[8] <= reg_wdata[0];
        reserved_q[1]                 <= reg_wdata[1];
      end
      if (wr_enable) begin
        group_int_enable_q <= reg_wdata[2:0];
      end
      if (wr_prio) begin
        priority_q <= reg_wdata[3:0];
      end
    end
  end

  // read mux; port data takes the raw pins, no synchroniser
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `OFF_INT_SEL0: begin
        rdata_d = per_bit_int_select_q[7:0];
      end
      `OFF_INT_SEL1: begin
        rdata_d = {6'h00, reserved_q[0], per_bit_int_select_q[8]};
      end
      `OFF_CMP_POL0: begin
        rdata_d = per_bit_compare_polarity_q[7:0];
      end
      `OFF_CMP_POL1: begin
        rdata_d = {6'h00, reserved_q[1], per_bit_compare_polarity_q[8]};
      end
      `OFF_PORT_DATA0: begin
        rdata_d = bank0_input_pins;
      end
      `OFF_PORT_DATA1: begin
        rdata_d = {7'h00, extra_input_pin};
      end
      `OFF_INT_STATUS: begin
        rdata_d = {5'h00, group_factor_flag_q};
      end
      `OFF_INT_ENABLE: begin
        rdata_d = {5'h00, group_int_enable_q};
      end
      `OFF_PRIORITY: begin
        rdata_d = {4'h0, priority_q};
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // data stands only in the cycle after the strobe, zero otherwise
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign group_irq      = group_factor_flag_q & group_int_enable_q;
  assign irq            = |group_irq;
  assign bank0_priority = priority_q[1:0];
  assign extra_priority = priority_q[3:2];

  // extra pin first, then high, then low nibble; the order is a local
  // choice, the controller may still rank by priority level
  always @* begin
    vector_d = 24'h000000;
    case (group_irq)
      3'b001: begin
        vector_d = `VEC_LOW;
      end
      3'b010, 3'b011: begin
        vector_d = `VEC_HIGH;
      end
      3'b100, 3'b101, 3'b110, 3'b111: begin
        vector_d = `VEC_EXTRA;
      end
      default: begin
        vector_d = 24'h000000;
      end
    endcase
  end

  // registered so the vector is glitch free, one cycle behind the request
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_vector <= 24'h000000;
    end else begin
      irq_vector <= vector_d;
    end
  end

endmodule
`default_nettype wire

// ### dv/input_port_chk.sv
// checker for the input port
`timescale 1ns/1ps
`default_nettype none
module input_port_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic        irq,
  input wire logic        extra_input_pin,
  input wire logic        event_counter_clock_in,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [8:0]  pullup_enable,
  input wire logic [1:0]  bank0_priority,
  input wire logic [1:0]  extra_priority,
  input wire logic [2:0]  group_irq,
  input wire logic [23:0] irq_vector
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ev_copy_a: assert property (event_counter_clock_in == extra_input_pin) else $error("ev");
  irq_or_a: assert property (irq == (|group_irq)) else $error("irq");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("idle");
  rd_unmap_a: assert property (reg_rd && reg_addr == 4'h9 |=> reg_rdata == 8'h00) else $error("unmap");
  rd_pin8_a: assert property (reg_rd && reg_addr == 4'h5 |=> reg_rdata == {7'h00, $past(extra_input_pin)})
    else $error("pin8");
  vec_low_a: assert property ($past(group_irq) == 3'b001 |-> irq_vector == 24'h00000e) else $error("vl");
  vec_ext_a: assert property ($past(group_irq[2]) |-> irq_vector == 24'h00000a) else $error("ve");
  flag_hold_a: assert property ($fell(group_irq[0]) |-> $past(reg_wr)) else $error("flag");
  pullup_fix_a: assert property (pullup_enable == 9'h1ff) else $error("pullup");
  prio_wr_a: assert property (reg_wr && reg_addr == 4'h8 |=> {extra_priority, bank0_priority} == $past(reg_wdata[3:0]))
    else $error("prio");
  cover property (group_irq[0]);
  cover property (group_irq[2]);
  cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind input_port_edge_interrupt input_port_chk input_port_chk_i (.*);
`default_nettype wire

// ### dv/key_switches.sv
// partner model: keys and switches on the nine pins
`timescale 1ns/1ps
`default_nettype none
module key_switches (input wire logic clk_sys, input wire logic [8:0] key_level,
  output var logic [7:0] bank0_input_pins, output var logic extra_input_pin);
  // one clock of lag stands in for the slow pull-up rise
  always @(posedge clk_sys) {extra_input_pin, bank0_input_pins} <= key_level;
endmodule
`default_nettype wire

// ### dv/input_port_edge_interrupt_tb.sv
// bench for the input port
`timescale 1ns/1ps
`default_nettype none
module input_port_edge_interrupt_tb;
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, extra_input_pin, irq;
  logic [8:0] key_level = 9'h1ff;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, bank0_input_pins, reg_rdata;
  int err_count = 0, checked = 0;
  always #2 clk_sys = ~clk_sys;
  key_switches key_switches_i (.*);
  input_port_edge_interrupt input_port_edge_interrupt_i (.*, .pullup_enable(), .event_counter_clock_in(),
    .group_irq(), .bank0_priority(), .extra_priority(), .irq_vector());
  task automatic chk(input logic ok);
    checked++;
    if (!ok) err_count++;
    if (!ok) $display("[FAIL] %0t mismatch", $time);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    {reg_wr, reg_rd} <= {w, !w};
    @(posedge clk_sys);
    {reg_wr, reg_rd} <= 2'b00;
    #1;
    if (!w) chk(reg_rdata === d);
  endtask
  task automatic keys(input logic [8:0] v, input logic e);
    @(posedge clk_sys);
    key_level <= v;
    repeat (6) @(negedge clk_sys);
    chk(irq === e);
  endtask
  task automatic low_grp;
    bus(0, 4'h1, 8'h00);
    bus(1, 4'h8, 8'h09);
    bus(0, 4'h8, 8'h09);
    bus(1, 4'h7, 8'h01);
    bus(1, 4'h0, 8'h05);
    keys(9'h1fc, 1'b1);
    bus(1, 4'h6, 8'h01);
    keys(9'h1f8, 1'b0);
    keys(9'h1fd, 1'b0);
    keys(9'h1fb, 1'b1);
    bus(1, 4'h6, 8'h01);
  endtask
  task automatic extra_grp;
    bus(0, 4'h3, 8'h03);
    bus(1, 4'h3, 8'h02);
    keys(9'h0fb, 1'b0);
    bus(1, 4'h1, 8'h01);
    keys(9'h1fb, 1'b0);
    bus(0, 4'h6, 8'h04);
    bus(0, 4'h5, 8'h01);
    bus(0, 4'h9, 8'h00);
    bus(1, 4'h7, 8'h04);
    chk(irq === 1'b1);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    low_grp;
    extra_grp;
    give_verdict;
  end
  initial begin
    #4000 err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
